// ### mfd_params.svh
// constants for the micro floppy drive controller
`ifndef MFD_PARAMS_SVH
`define MFD_PARAMS_SVH
// ----------------------------------------
// timing and track limit
// ----------------------------------------
`define MFD_CLK_MHZ 200
`define MFD_STEP_MS 10
`define MFD_HOLD_US 1000
`define MFD_READY_MS 1500
`define MFD_RECAL_MS 3000
`define MFD_REV_MS 200
`define MFD_INDEX_US 2000
`define MFD_SEQ_MS 100
`define MFD_MAX_TRACK 79
// ----------------------------------------
// register map
// ----------------------------------------
`define MFD_OFS_CTRL 32'h0000_0000
`define MFD_OFS_STATUS 32'h0000_0004
`define MFD_OFS_IRQ_STAT 32'h0000_0008
`define MFD_OFS_IRQ_MASK 32'h0000_000C
`define MFD_CTRL_RST 2'h0
`define MFD_MASK_RST 4'h0
// irq bits
`define MFD_IRQ_INS 0
`define MFD_IRQ_EJECT 1
`define MFD_IRQ_RECAL 2
`define MFD_IRQ_LOCK 3
// status bits
`define MFD_ST_RUN 8
`define MFD_ST_LOCK 9
`define MFD_ST_SPIN 10
`define MFD_ST_READY 11
`define MFD_ST_CHG 12
`define MFD_ST_DISK 13
`endif

// ### mfd_pkg.sv
// types and helpers for the micro floppy drive controller
`default_nettype none
package mfd_pkg;
    typedef enum logic [1:0] {MFD_RECAL, MFD_RUN, MFD_LOCK} mfd_state_e;
    typedef enum logic [1:0] {MFD_SQ_IDLE, MFD_SQ_SPIN, MFD_SQ_LOAD, MFD_SQ_UNLOAD} mfd_seq_e;

    function automatic logic [3:0] mfd_phase_pat(input logic [1:0] p);
        case (p)
            2'h0: return 4'h3;
            2'h1: return 4'h6;
            2'h2: return 4'hC;
            default: return 4'h9;
        endcase
    endfunction : mfd_phase_pat
endpackage : mfd_pkg
`default_nettype wire

// ### mfd_ctrl.sv
// micro floppy drive control logic with ahb-lite register slave
// Function
// [RL1] at power-up step outward until track zero, then hold there
// [RL2] spindle stays stopped after power-up until motor request or insertion
// [RL3] status outputs driven only while host select matches configured position
// [RL4] insertion: spin motor, plunger, load then unload head, stop motor
// [RL5] motor-on with disk present spins spindle, one index pulse per revolution
// [RL6] ready asserts about 1.5 s after insertion with motor running, not before
// [RL7] change-reset input clears disk-changed output at once
// [RL8] eject sets disk-changed, held until change-reset clears it
// [RL9] head-load request energises plunger solenoid
// [RL10] inward steps stop at track 79, outward steps stop at track 00
// [RL11] track-zero output inactive on any track other than zero
// [RL12] no track zero within seconds of power-up: stepper off, commands ignored
// [RL13] recalibration advances phase outputs every 10 ms within 0.1 ms
// [RL14] stepper stays energised about 1 ms after each step pulse
// [RL15] side select picks head 0 or 1, write current only to it
// [RL16] write gate active low, write driver enabled only while low
// [RL17] track-zero, write-protect, ready, disk-changed outputs active low
// [RL18] phase outputs follow track modulo four: HHLL, LHHL, LLHH, HLLH
// [RL19] each accepted step moves exactly one track and updates position
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`include "mfd_params.svh"
`default_nettype none
module mfd_ctrl
    import mfd_pkg::*;
#(
    parameter int unsigned MAX_TRACK = `MFD_MAX_TRACK,
    parameter int unsigned STEP_CYC = `MFD_STEP_MS * `MFD_CLK_MHZ * 1000,
    parameter int unsigned HOLD_CYC = `MFD_HOLD_US * `MFD_CLK_MHZ,
    parameter int unsigned READY_CYC = `MFD_READY_MS * `MFD_CLK_MHZ * 1000,
    parameter int unsigned RECAL_CYC = `MFD_RECAL_MS * `MFD_CLK_MHZ * 1000,
    parameter int unsigned REV_CYC = `MFD_REV_MS * `MFD_CLK_MHZ * 1000,
    parameter int unsigned INDEX_CYC = `MFD_INDEX_US * `MFD_CLK_MHZ,
    parameter int unsigned SEQ_CYC = `MFD_SEQ_MS * `MFD_CLK_MHZ * 1000
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    // host interface inputs
    input wire logic [3:0] drive_select_n,
    input wire logic motor_on_n,
    input wire logic step_n,
    input wire logic step_inward,
    input wire logic head_side,
    input wire logic head_load_n,
    input wire logic write_gate_n,
    input wire logic change_reset_n,
    // host interface outputs
    output logic track_zero_n,
    output logic write_protect_n,
    output logic ready_n,
    output logic disk_changed_n,
    output logic index_n,
    // mechanism sensors
    input wire logic cassette_inserted,
    input wire logic write_protect_tab,
    input wire logic track_zero_sensor,
    // mechanism drives
    output logic [3:0] phase,
    output logic stepper_on,
    output logic spindle_on,
    output logic plunger_on,
    output logic [1:0] write_enable
);
    // ----------------------------------------
    // parameter checks
    // ----------------------------------------
    generate
        if (MAX_TRACK < 4 || MAX_TRACK > 127 || STEP_CYC < 2 || HOLD_CYC < 2 ||
            INDEX_CYC >= REV_CYC || SEQ_CYC < 2 || READY_CYC < 2 ||
            RECAL_CYC < 2)
        begin : g_bad_param
            $error("mfd_ctrl: parameter values out of range");
        end
    endgenerate

    // ----------------------------------------
    // state
    // ----------------------------------------
    mfd_state_e st;
    mfd_seq_e seq;
    logic [6:0] track;
    logic [1:0] ph;
    logic [31:0] step_tmr;
    logic [31:0] recal_tmr;
    logic [31:0] hold_cnt;
    logic [31:0] rdy_cnt;
    logic [31:0] rev_cnt;
    logic [31:0] seq_cnt;
    logic primed;
    logic cass_q;
    logic step_n_q;
    logic dchg;
    logic [1:0] sel_pos;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic wr_pend;
    logic [31:0] wr_addr;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire selected = !drive_select_n[sel_pos];
    wire ins_ev = primed && cassette_inserted && !cass_q;
    wire eject_ev = primed && !cassette_inserted && cass_q;
    wire step_fall = step_n_q && !step_n;
    wire cmd_ok = (st == MFD_RUN); // [RL12]
    wire at_max = (track == 7'(MAX_TRACK));
    wire at_zero = (track == 7'h0);
    // edge of step_n is taken only inside the travel limits
    wire step_acc = cmd_ok && selected && step_fall &&
        (step_inward ? !at_max : !at_zero); // [RL10]
    wire step_tick = (step_tmr == 32'(STEP_CYC - 1)); // [RL13]
    wire recal_hit = (st == MFD_RECAL) && step_tick && track_zero_sensor;
    wire recal_fail = (st == MFD_RECAL) && !recal_hit &&
        (recal_tmr == 32'(RECAL_CYC - 1)); // [RL12]
    wire seq_tick = (seq_cnt == 32'(SEQ_CYC - 1));
    wire rdy_done = (rdy_cnt == 32'(READY_CYC)); // [RL6]

    // track and phase pointer updates
    wire [6:0] next_track = recal_hit ? 7'h0 :
        !step_acc ? track :
        step_inward ? track + 7'h1 : track - 7'h1; // [RL19]
    wire [1:0] next_ph = recal_hit ? 2'h0 :
        (st == MFD_RECAL && step_tick) ? ph - 2'h1 :
        step_acc ? next_track[1:0] : ph; // [RL1] [RL18]
    wire [31:0] next_hold = step_acc ? 32'(HOLD_CYC) :
        (hold_cnt != 32'h0000_0000) ? hold_cnt - 32'h0000_0001 :
        32'h0000_0000; // [RL14]
    wire next_stepper = (st == MFD_RECAL && !recal_fail) ||
        (st == MFD_RUN && next_hold != 32'h0000_0000); // [RL14]

    // spindle and plunger demand
    wire host_motor = cmd_ok && !motor_on_n && cassette_inserted; // [RL5]
    wire next_spin = host_motor || (seq != MFD_SQ_IDLE); // [RL2] [RL4]
    wire next_plunger = (cmd_ok && !head_load_n) ||
        (seq == MFD_SQ_LOAD); // [RL9] [RL4]
    wire next_dchg = eject_ev ? 1'b1 :
        !change_reset_n ? 1'b0 : dchg; // [RL7] [RL8]

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire addr_ok = hsel && hready && htrans[1];
    wire wr_ctrl = wr_pend && (wr_addr == `MFD_OFS_CTRL);
    wire wr_istat = wr_pend && (wr_addr == `MFD_OFS_IRQ_STAT);
    wire wr_imask = wr_pend && (wr_addr == `MFD_OFS_IRQ_MASK);
    wire [3:0] w1c = wr_istat ? hwdata[3:0] : 4'h0;
    wire [3:0] irq_ev = {recal_fail, recal_hit, eject_ev, ins_ev};
    wire [31:0] status_word = {18'h0_0000, cassette_inserted, dchg,
        rdy_done, spindle_on, (st == MFD_LOCK), (st == MFD_RUN), 1'b0, track};
    wire [31:0] rd_val =
        (haddr == `MFD_OFS_CTRL) ? {30'h0000_0000, sel_pos} :
        (haddr == `MFD_OFS_STATUS) ? status_word :
        (haddr == `MFD_OFS_IRQ_STAT) ? {28'h000_0000, irq_stat} :
        (haddr == `MFD_OFS_IRQ_MASK) ? {28'h000_0000, irq_mask} :
        32'h0000_0000;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(irq_stat & irq_mask);

    // ----------------------------------------
    // bus registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0000_0000;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            wr_pend <= addr_ok && hwrite;
            if (addr_ok)
                wr_addr <= haddr;
            if (addr_ok && !hwrite)
                hrdata <= rd_val;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sel_pos <= `MFD_CTRL_RST;
            irq_mask <= `MFD_MASK_RST;
            irq_stat <= 4'h0;
        end
        else
        begin
            if (wr_ctrl)
                sel_pos <= hwdata[1:0];
            if (wr_imask)
                irq_mask <= hwdata[3:0];
            // a new event beats a clear in the same cycle
            irq_stat <= (irq_stat & ~w1c) | irq_ev;
        end
    end

    // ----------------------------------------
    // input edge tracking
    // ----------------------------------------
    // primed blocks a false insertion edge in the first cycle after reset
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            primed <= 1'b0;
            cass_q <= 1'b0;
            step_n_q <= 1'b1;
        end
        else
        begin
            primed <= 1'b1;
            cass_q <= cassette_inserted;
            step_n_q <= step_n;
        end
    end

    // ----------------------------------------
    // head positioning
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st <= MFD_RECAL;
            track <= 7'h0;
            ph <= 2'h0;
            step_tmr <= 32'h0000_0000;
            recal_tmr <= 32'h0000_0000;
            hold_cnt <= 32'h0000_0000;
        end
        else
        begin
            track <= next_track;
            ph <= next_ph;
            hold_cnt <= next_hold;
            case (st)
                MFD_RECAL:
                begin
                    step_tmr <= step_tick ? 32'h0000_0000 :
                        step_tmr + 32'h0000_0001;
                    recal_tmr <= recal_tmr + 32'h0000_0001;
                    if (recal_hit)
                        st <= MFD_RUN; // [RL1]
                    else if (recal_fail)
                        st <= MFD_LOCK; // [RL12]
                end
                MFD_RUN: st <= MFD_RUN;
                MFD_LOCK: st <= MFD_LOCK;
                default: st <= MFD_LOCK;
            endcase
        end
    end

    // phase outputs stay registered so the coil pattern never glitches
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            phase <= mfd_phase_pat(2'h0);
            stepper_on <= 1'b0;
        end
        else
        begin
            phase <= mfd_phase_pat(next_ph); // [RL18] [RL13]
            stepper_on <= next_stepper; // [RL14] [RL12]
        end
    end

    // ----------------------------------------
    // insertion sequence
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            seq <= MFD_SQ_IDLE;
            seq_cnt <= 32'h0000_0000;
        end
        else
        begin
            seq_cnt <= (seq == MFD_SQ_IDLE || seq_tick) ? 32'h0000_0000 :
                seq_cnt + 32'h0000_0001;
            case (seq)
                MFD_SQ_IDLE: if (ins_ev) seq <= MFD_SQ_SPIN; // [RL4]
                MFD_SQ_SPIN: if (seq_tick) seq <= MFD_SQ_LOAD;
                MFD_SQ_LOAD: if (seq_tick) seq <= MFD_SQ_UNLOAD;
                MFD_SQ_UNLOAD: if (seq_tick) seq <= MFD_SQ_IDLE;
                default: seq <= MFD_SQ_IDLE;
            endcase
            if (!cassette_inserted)
                seq <= MFD_SQ_IDLE;
        end
    end

    // ----------------------------------------
    // spindle, index and ready
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            spindle_on <= 1'b0;
            plunger_on <= 1'b0;
            rev_cnt <= 32'h0000_0000;
            rdy_cnt <= 32'h0000_0000;
        end
        else
        begin
            spindle_on <= next_spin; // [RL2] [RL5]
            plunger_on <= next_plunger; // [RL9]
            if (!spindle_on || !cassette_inserted)
                rev_cnt <= 32'h0000_0000;
            else if (rev_cnt == 32'(REV_CYC - 1))
                rev_cnt <= 32'h0000_0000; // [RL5]
            else
                rev_cnt <= rev_cnt + 32'h0000_0001;
            // ready time runs from insertion; removal restarts it
            if (!cassette_inserted)
                rdy_cnt <= 32'h0000_0000;
            else if (!rdy_done)
                rdy_cnt <= rdy_cnt + 32'h0000_0001; // [RL6]
        end
    end

    // ----------------------------------------
    // host status outputs
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            dchg <= 1'b0;
            track_zero_n <= 1'b1;
            write_protect_n <= 1'b1;
            ready_n <= 1'b1;
            disk_changed_n <= 1'b1;
            index_n <= 1'b1;
        end
        else
        begin
            dchg <= next_dchg; // [RL8]
            track_zero_n <= !(selected && st == MFD_RUN &&
                next_track == 7'h0); // [RL3] [RL11] [RL17]
            write_protect_n <= !(selected && cassette_inserted &&
                write_protect_tab); // [RL3] [RL17]
            ready_n <= !(selected && rdy_done && spindle_on); // [RL6] [RL17]
            disk_changed_n <= !(selected && next_dchg); // [RL3] [RL7] [RL17]
            index_n <= !(selected && spindle_on && cassette_inserted &&
                rev_cnt < 32'(INDEX_CYC)); // [RL5]
        end
    end

    // ----------------------------------------
    // write drivers, one per head
    // ----------------------------------------
    genvar h;
    generate
        for (h = 0; h < 2; h++)
        begin : g_head
            always_ff @(posedge clk)
            begin
                if (!resetn)
                    write_enable[h] <= 1'b0;
                else
                    write_enable[h] <= cmd_ok && selected && !write_gate_n &&
                        (head_side == 1'(h)) && cassette_inserted &&
                        !write_protect_tab; // [RL15] [RL16]
            end
        end
    endgenerate

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_sel_gate;
        !selected |=> (track_zero_n && write_protect_n && disk_changed_n);
    endproperty
    a_sel_gate: assert property (p_sel_gate) // [RL3]
        else $error("status output active while not selected");

    property p_chg_clear;
        (!change_reset_n && !eject_ev) |=> (disk_changed_n && !dchg);
    endproperty
    a_chg_clear: assert property (p_chg_clear) // [RL7]
        else $error("change reset did not clear disk changed");

    sequence s_eject;
        eject_ev ##1 dchg;
    endsequence
    property p_eject_set;
        eject_ev |-> s_eject;
    endproperty
    a_eject_set: assert property (p_eject_set) // [RL8]
        else $error("eject did not set disk changed");

    property p_limit;
        (cmd_ok && step_fall && step_inward && at_max) |=> at_max;
    endproperty
    a_limit: assert property (p_limit) // [RL10]
        else $error("head stepped past last track");

    property p_step_one;
        (step_acc && step_inward) |=> (track == $past(track) + 7'h1);
    endproperty
    a_step_one: assert property (p_step_one) // [RL19]
        else $error("inward step did not move one track");

    property p_phase;
        (st == MFD_RUN && $past(st) == MFD_RUN) |->
            (phase == mfd_phase_pat(track[1:0]));
    endproperty
    a_phase: assert property (p_phase) // [RL18]
        else $error("phase pattern does not match track");

    property p_trk0;
        (track != 7'h0 && !step_acc) |=> track_zero_n;
    endproperty
    a_trk0: assert property (p_trk0) // [RL11]
        else $error("track zero active off track zero");

    property p_hold;
        step_acc |=> stepper_on [*8];
    endproperty
    a_hold: assert property (p_hold) // [RL14]
        else $error("stepper released too soon after step");

    property p_wgate;
        write_gate_n |=> (write_enable == 2'h0);
    endproperty
    a_wgate: assert property (p_wgate) // [RL16]
        else $error("write driver on with gate high");

    property p_lock;
        (st == MFD_LOCK) |=> (!stepper_on && !spindle_on ||
            seq != MFD_SQ_IDLE) && track == $past(track);
    endproperty
    a_lock: assert property (p_lock) // [RL12]
        else $error("locked drive still acting on commands");

    property p_recal_tick;
        (st == MFD_RECAL && step_tick && !track_zero_sensor && !recal_fail)
            |=> (ph == $past(ph) - 2'h1);
    endproperty
    a_recal_tick: assert property (p_recal_tick) // [RL13]
        else $error("recalibration phase did not advance");
endmodule : mfd_ctrl
`default_nettype wire

// ### mfd_host.sv
// host controller model driving the drive's host-side lines
`default_nettype none
module mfd_host
(
    // clock
    input wire logic clk,
    // host lines towards the drive
    output var logic [3:0] drive_select_n,
    output var logic motor_on_n,
    output var logic step_n,
    output var logic step_inward,
    output var logic head_side,
    output var logic head_load_n,
    output var logic write_gate_n,
    output var logic change_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // idle levels and requests
    // ----------------------------------------
    initial
    begin
        drive_select_n = 4'hE;
        {motor_on_n, step_n, step_inward, head_side} = 4'hC;
        {head_load_n, write_gate_n, change_reset_n} = 3'h7;
    end

    // levels: select lines, motor, head load, side, write
    task automatic lv(input logic [3:0] sel, input logic mot, hl, sd, wr);
        @(posedge clk);
        drive_select_n <= sel;
        motor_on_n <= ~mot;
        head_load_n <= ~hl;
        head_side <= sd;
        write_gate_n <= ~wr;
    endtask : lv

    // one step; low for two edges so the edge detector sees it once
    task automatic step(input logic dir);
        @(posedge clk);
        step_inward <= dir;
        step_n <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        step_n <= 1'b1;
        @(posedge clk);
    endtask : step

    // short pulse on the change-reset line
    task automatic crst();
        @(posedge clk);
        change_reset_n <= 1'b0;
        @(posedge clk);
        change_reset_n <= 1'b1;
    endtask : crst
endmodule : mfd_host
`default_nettype wire

// ### micro_floppy_drive_control_tb_top.sv
// self-checking testbench for the micro floppy drive controller
`default_nettype none
`include "mfd_params.svh"
module micro_floppy_drive_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // shortened counts keep the run small
    localparam int STEP = 20, HOLD = 10, RDY = 200, RCL = 500, REV = 100, IDX = 5, SEQ = 10;
    localparam logic [3:0] PAT [4] = '{4'h3, 4'h6, 4'hC, 4'h9};
    logic clk, resetn, hsel, hwrite, irq, hreadyout, hresp, ph_mv, ph_q, idx_q;
    logic [1:0] htrans, wen;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [31:0] seed = 32'h15f0_3c28;
    logic [3:0] sel_n, ph, ph_d;
    logic mot_n, stp_n, stp_in, side, hl_n, wg_n, crst_n;
    logic tz_n, wp_n, rdy_n, dc_n, idx_n, cas, wpt, tzs, stp_on, spin, plg;
    int failures, n_checks, cyc, trk, t0, k;

    mfd_ctrl #(.STEP_CYC(STEP), .HOLD_CYC(HOLD), .READY_CYC(RDY), .RECAL_CYC(RCL),
        .REV_CYC(REV), .INDEX_CYC(IDX), .SEQ_CYC(SEQ)) DUT (
        .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .drive_select_n(sel_n), .motor_on_n(mot_n), .step_n(stp_n), .step_inward(stp_in),
        .head_side(side), .head_load_n(hl_n), .write_gate_n(wg_n), .change_reset_n(crst_n),
        .track_zero_n(tz_n), .write_protect_n(wp_n), .ready_n(rdy_n), .disk_changed_n(dc_n),
        .index_n(idx_n), .cassette_inserted(cas), .write_protect_tab(wpt),
        .track_zero_sensor(tzs), .phase(ph), .stepper_on(stp_on), .spindle_on(spin),
        .plunger_on(plg), .write_enable(wen));
    mfd_host host (.clk(clk), .drive_select_n(sel_n), .motor_on_n(mot_n), .step_n(stp_n),
        .step_inward(stp_in), .head_side(side), .head_load_n(hl_n), .write_gate_n(wg_n),
        .change_reset_n(crst_n));

    // ----------------------------------------
    // clock, monitors and helpers
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        ph_d <= ph;
        idx_q <= idx_n;
    end
    always_comb ph_mv = (ph !== ph_d);
    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        $display("[ERR] %0t run too long", $time);
        conclude();
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic conclude();
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // bounded wait; a level that never comes ends the run
    task automatic wt(ref logic s, input logic v, input int n);
        for (int i = 0; s !== v; i++)
        begin
            if (i == n)
            begin
                failures++;
                $display("[ERR] %0t wait ran out", $time);
                conclude();
            end
            @(posedge clk);
        end
    endtask : wt

    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        wt(hreadyout, 1'b1, 20);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        wt(hreadyout, 1'b1, 20);
        rd = hrdata;
    endtask : bus

    task automatic chkr(input logic [31:0] a, m, e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd & m, e, "register");
        chk(hresp, 1'b0, "bus response");
    endtask : chkr

    // step with the reference track position beside it
    task automatic stp(input logic dir);
        host.step(dir);
        if (dir && trk < 79)
            trk++;
        else if (!dir && trk > 0)
            trk--;
        chk(ph, PAT[trk % 4], "phase");
        chk(tz_n, trk != 0, "track zero");
        chk(stp_on, 1'b1, "stepper hold");
    endtask : stp

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {resetn, hsel, hwrite, cas, wpt, tzs} = 6'h00;
        htrans = 2'h0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        repeat (8) @(posedge clk);
        chk({tz_n, wp_n, rdy_n, dc_n, idx_n, irq, spin}, 7'h7C, "reset levels");
        resetn <= 1'b1;
        wt(ph_mv, 1'b1, 3 * STEP);
        t0 = cyc;
        @(posedge clk);
        wt(ph_mv, 1'b1, 3 * STEP);
        chk(cyc - t0, STEP, "recal tick");
        chk(ph, 4'hC, "outward order");
        chk(spin, 1'b0, "spindle idle");
        tzs <= 1'b1;
        wt(tz_n, 1'b0, 3 * STEP);
        chk(ph, 4'h3, "home phase");
        chkr(`MFD_OFS_STATUS, 32'h0000_077F, 32'h0000_0100);
        chkr(`MFD_OFS_IRQ_STAT, 32'h0000_000F, 32'h0000_0004);
        chk(irq, 1'b0, "irq masked");
        bus(1'b1, `MFD_OFS_IRQ_MASK, 32'h0000_0004);
        @(posedge clk);
        chk(irq, 1'b1, "irq raised");
        bus(1'b1, `MFD_OFS_IRQ_STAT, 32'h0000_0004);
        @(posedge clk);
        chk(irq, 1'b0, "irq cleared");
        chkr(`MFD_OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0004);
        bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
        chkr(32'h0000_0010, 32'hFFFF_FFFF, 32'h0000_0000);
        for (k = 0; k < 8; k++)
        begin
            bus(1'b1, `MFD_OFS_CTRL, k % 4);
            host.lv(4'(rnd()), 1'b0, 1'b0, 1'b0, 1'b0);
            repeat (2) @(posedge clk);
            chk({tz_n, wp_n, dc_n}, {sel_n[k % 4], 2'h3}, "select gate");
        end
        bus(1'b1, `MFD_OFS_CTRL, 32'h0000_0000);
        host.lv(4'hE, 1'b0, 1'b0, 1'b0, 1'b0);
        // travel past both end stops
        trk = 0;
        for (k = 0; k < 162; k++)
            stp(k < 81);
        repeat (HOLD + 3) @(posedge clk);
        chk(stp_on, 1'b0, "stepper released");
        chkr(`MFD_OFS_STATUS, 32'h0000_007F, 32'h0000_0000);
        @(posedge clk);
        cas <= 1'b1;
        t0 = cyc;
        wt(spin, 1'b1, 5);
        wt(plg, 1'b1, SEQ + 5);
        wt(plg, 1'b0, SEQ + 5);
        wt(spin, 1'b0, SEQ + 5);
        host.lv(4'hE, 1'b1, 1'b0, 1'b0, 1'b0);
        wt(spin, 1'b1, 5);
        wt(rdy_n, 1'b0, RDY);
        chk(cyc - t0 >= RDY, 1'b1, "ready too soon");
        k = 0;
        repeat (4 * REV)
        begin
            @(posedge clk);
            k += (idx_q === 1'b1 && idx_n === 1'b0);
        end
        chk(k, 4, "index count");
        host.lv(4'hE, 1'b1, 1'b1, 1'b0, 1'b0);
        repeat (2) @(posedge clk);
        chk(plg, 1'b1, "head load");
        for (k = 0; k < 4; k++)
        begin
            wpt <= k[1];
            host.lv(4'hE, 1'b1, 1'b0, k[0], 1'b1);
            repeat (2) @(posedge clk);
            chk({wp_n, wen}, {!k[1], k[1] ? 2'h0 : (k[0] ? 2'h2 : 2'h1)}, "write");
        end
        host.lv(4'hE, 1'b1, 1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clk);
        chk(wen, 2'h0, "write gate off");
        cas <= 1'b0;
        repeat (3) @(posedge clk);
        chk(dc_n, 1'b0, "changed set");
        repeat (20) @(posedge clk);
        chk(dc_n, 1'b0, "changed held");
        host.crst();
        repeat (2) @(posedge clk);
        chk(dc_n, 1'b1, "changed cleared");
        chkr(`MFD_OFS_IRQ_STAT, 32'h0000_000F, 32'h0000_0003);
        // second power-up with the home sensor dead
        resetn <= 1'b0;
        tzs <= 1'b0;
        host.lv(4'hE, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t0 = cyc;
        wt(stp_on, 1'b1, 5);
        wt(stp_on, 1'b0, RCL + 50);
        chk(cyc - t0 >= RCL, 1'b1, "lockout too soon");
        chkr(`MFD_OFS_STATUS, 32'h0000_0300, 32'h0000_0200);
        chkr(`MFD_OFS_IRQ_STAT, 32'h0000_0008, 32'h0000_0008);
        k = ph;
        host.step(1'b1);
        chk(ph, k, "locked phase");
        chk(stp_on, 1'b0, "locked stepper");
        conclude();
    end
endmodule : micro_floppy_drive_control_tb_top
`default_nettype wire
